// ### shared/clkdiv_map.svh
// register offsets, reset values, field positions of the divider bank
`ifndef CLKDIV_MAP_SVH
`define CLKDIV_MAP_SVH

// --------------------------------------------------------------------
// register offsets (byte addresses on the programming port)
// --------------------------------------------------------------------
`define CDR_OUT2_MID_OFS 8'h1d
`define CDR_OUT2_LOW_OFS 8'h1e
`define CDR_OUT3_HIGH_OFS 8'h1f
`define CDR_OUT3_MID_OFS 8'h20
`define CDR_OUT3_LOW_OFS 8'h21
`define CDR_OUT4_HIGH_OFS 8'h22
`define CDR_OUT4_MID_OFS 8'h23
`define CDR_OUT4_LOW_OFS 8'h24
`define CDR_OUT5_HIGH_OFS 8'h25
`define CDR_OUT5_MID_OFS 8'h26
`define CDR_OUT5_LOW_OFS 8'h27
`define CDR_FB_CTRL_OFS 8'h28
`define CDR_FB_MID_OFS 8'h29

// --------------------------------------------------------------------
// reset values and writable masks
// --------------------------------------------------------------------
`define CDR_ZERO_RST 8'h00
`define CDR_LOW_BYTE_RST 8'h31
`define CDR_FB_CTRL_RST 8'hc0
`define CDR_NIBBLE_MASK 8'h0f
`define CDR_FB_CTRL_MASK 8'hef
`define CDR_FULL_MASK 8'hff

// --------------------------------------------------------------------
// field positions and decode constants
// --------------------------------------------------------------------
`define CDR_HS_CODE_MSB 7
`define CDR_HS_CODE_LSB 5
`define CDR_RSVD_BIT 4
`define CDR_HS_RATIO_BASE 4'h4

`endif

// ### shared/clkdiv_pkg.sv
// types shared by the divider configuration bank
package clkdiv_pkg;
  typedef logic [7:0] byte_t;      // one programming-port register
  typedef logic [19:0] ratio_t;    // one 20-bit divider field
  typedef logic [2:0] hs_code_t;   // high-speed divider code
  typedef logic [3:0] hs_ratio_t;  // decoded high-speed ratio 4..11
endpackage

// ### shared/ratio_if.sv
// staged/active handshake between the register file and a ratio shadow
`timescale 1ns/1ps
`default_nettype none
interface ratio_if;
  clkdiv_pkg::ratio_t staged;  // bytes as software last wrote them
  logic commit;                // one-cycle load strobe
  clkdiv_pkg::ratio_t active;  // ratio the divider really uses
  modport src (output staged, output commit, input active);
  modport shd (input staged, input commit, output active);
endinterface
`default_nettype wire

// ### design/ratio_shadow.sv
// active copy of one divider ratio, loaded whole on a commit strobe
`timescale 1ns/1ps
`default_nettype none
module ratio_shadow #(
  parameter clkdiv_pkg::ratio_t RST = 20'h0_0000
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // staged ratio in, active ratio out
  ratio_if.shd rif
);

  // --------------------------------------------------------------------
  // shadow register
  // --------------------------------------------------------------------
  // the divider only ever sees a full ratio, never a half-written one
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rif.active <= RST;
    end else if (rif.commit) begin
      rif.active <= rif.staged;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  a_shadow_hold: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !rif.commit |=> $stable(rif.active))
    else $error("active ratio changed without commit");

endmodule
`default_nettype wire

// ### design/hs_decode.sv
// decode of a 3-bit high-speed divider code into its ratio
`timescale 1ns/1ps
`default_nettype none
`include "clkdiv_map.svh"
module hs_decode (
  // code in
  input wire clkdiv_pkg::hs_code_t code_in,
  // decoded ratio and coarse-skew block
  output logic [3:0] ratio_out,
  output logic skew_block_out
);

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  // ratio is code plus four: 000 -> 4 up to 111 -> 11
  always_comb begin
    ratio_out = {1'b0, code_in} + `CDR_HS_RATIO_BASE;
    // smallest ratio cannot take coarse skew steps from the pin
    skew_block_out = (code_in == 3'h0);
  end

endmodule
`default_nettype wire

// ### design/clkdiv_cfg_regs.sv
// divider ratio configuration bank behind the programming port
//
// Overview of operation
// - third output ratio, 20 bits, zero or odd
// - fourth output ratio, 20 bits, zero or odd
// - fifth output ratio, 20 bits, zero or odd
// - feedback high-speed code decodes to code plus four
// - feedback low-speed upper nibble, bit four reserved
// - feedback low-speed field is ratio minus one
// - feedback control register resets to 1100 0000
// - low bytes reset 0x31, feedback control 0xc0, others zero
// - shared prescaler 4..11, code zero blocks skew
`timescale 1ns/1ps
`default_nettype none
`include "clkdiv_map.svh"
module clkdiv_cfg_regs (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // register access from the programming port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // fields held by neighbouring registers
  input wire logic [7:0] fb_lowspeed_low_byte_in,
  input wire logic [2:0] shared_output_prescaler_code_in,
  // output divider ratios
  output logic [15:0] second_output_divider_out,
  output logic [19:0] third_output_divider_out,
  output logic [19:0] fourth_output_divider_out,
  output logic [19:0] fifth_output_divider_out,
  output logic [2:0] div_legal_out,
  // feedback path and shared prescaler
  output logic [3:0] feedback_highspeed_ratio_out,
  output logic [20:0] feedback_lowspeed_ratio_out,
  output logic feedback_lowspeed_legal_out,
  output logic [3:0] shared_output_prescaler_ratio_out,
  output logic coarse_skew_block_out
);

  // --------------------------------------------------------------------
  // constants
  // --------------------------------------------------------------------
  localparam int NREG = 13;  // registers in the bank
  localparam int NCH = 5;    // out2..out5 and feedback
  localparam logic [7:0] FIRST = `CDR_OUT2_MID_OFS;
  localparam logic [7:0] LAST = `CDR_FB_MID_OFS;
  localparam clkdiv_pkg::byte_t FB_RST = `CDR_FB_CTRL_RST;
  // index of the last byte of each ratio; writing it commits the ratio
  localparam logic [3:0] COMMIT_IDX [NCH] = '{4'h1, 4'h4, 4'h7, 4'ha,
                                              4'hc};
  // reset ratios laid out like the staged words below
  localparam clkdiv_pkg::ratio_t RST_LOW = {12'h000, `CDR_LOW_BYTE_RST};
  localparam clkdiv_pkg::ratio_t RST_FB =
    {5'h00, FB_RST[7:5], FB_RST[3:0], `CDR_ZERO_RST};
  localparam clkdiv_pkg::ratio_t RST_CH [NCH] =
    '{RST_LOW, RST_LOW, RST_LOW, RST_LOW, RST_FB};

  // --------------------------------------------------------------------
  // reset value and writable mask per register
  // --------------------------------------------------------------------
  function automatic clkdiv_pkg::byte_t rst_of(input logic [3:0] i);
    case (i)
      4'h1, 4'h4, 4'h7, 4'ha: rst_of = `CDR_LOW_BYTE_RST;
      4'hb: rst_of = `CDR_FB_CTRL_RST;
      default: rst_of = `CDR_ZERO_RST;
    endcase
  endfunction

  function automatic clkdiv_pkg::byte_t mask_of(input logic [3:0] i);
    case (i)
      4'h2, 4'h5, 4'h8: mask_of = `CDR_NIBBLE_MASK;
      4'hb: mask_of = `CDR_FB_CTRL_MASK;
      default: mask_of = `CDR_FULL_MASK;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------
  logic in_range;           // address falls inside the bank
  logic [7:0] idx_full;     // address minus first offset
  logic [3:0] idx;          // register index 0..12
  logic wr_hit;             // accepted write this cycle
  logic is_commit;          // write hits the last byte of some ratio
  clkdiv_pkg::byte_t regs_r [NREG]; // staged register contents
  logic [NCH-1:0] commit_r;         // per-ratio load strobe
  logic [NCH-1:0][19:0] staged_w;   // staged ratio words
  logic [NCH-1:0][19:0] active_w;   // active ratio words

  assign idx_full = reg_addr_in - FIRST;
  assign idx = idx_full[3:0];

  // range check first, so unmapped offsets never touch the array
  always_comb begin
    if (reg_addr_in < FIRST) begin
      in_range = 1'b0;
    end else if (reg_addr_in > LAST) begin
      in_range = 1'b0;
    end else begin
      in_range = 1'b1;
    end
  end

  assign wr_hit = reg_wr_in && in_range;
  assign is_commit = (idx == COMMIT_IDX[0]) || (idx == COMMIT_IDX[1]) ||
                     (idx == COMMIT_IDX[2]) || (idx == COMMIT_IDX[3]) ||
                     (idx == COMMIT_IDX[4]);

  // --------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------
  // reserved bits are masked on the way in, so they always read zero
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NREG; i++) begin
        regs_r[i] <= rst_of(4'(i));
      end
    end else if (wr_hit) begin
      regs_r[idx] <= reg_wdata_in & mask_of(idx);
    end
  end

  // --------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------
  // unmapped reads answer zero one cycle after the strobe
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in && in_range) begin
        reg_rdata_out <= regs_r[idx];
      end else if (reg_rd_in) begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // --------------------------------------------------------------------
  // commit strobes
  // --------------------------------------------------------------------
  // delayed one cycle so the shadow sees the byte just written
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      commit_r <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        commit_r[c] <= wr_hit && (idx == COMMIT_IDX[c]);
      end
    end
  end

  // --------------------------------------------------------------------
  // staged ratio words, lowest offset most significant
  // --------------------------------------------------------------------
  always_comb begin
    staged_w[0] = {4'h0, regs_r[0], regs_r[1]};
    staged_w[1] = {regs_r[2][3:0], regs_r[3], regs_r[4]};
    staged_w[2] = {regs_r[5][3:0], regs_r[6], regs_r[7]};
    staged_w[3] = {regs_r[8][3:0], regs_r[9], regs_r[10]};
    staged_w[4] = {5'h00, regs_r[11][`CDR_HS_CODE_MSB:`CDR_HS_CODE_LSB],
                   regs_r[11][3:0], regs_r[12]};
  end

  // --------------------------------------------------------------------
  // one shadow per ratio
  // --------------------------------------------------------------------
  ratio_if rif [NCH] ();

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign rif[c].staged = staged_w[c];
    assign rif[c].commit = commit_r[c];
    assign active_w[c] = rif[c].active;
    ratio_shadow #(.RST(RST_CH[c])) u_shadow (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .rif(rif[c])
    );
  end

  // --------------------------------------------------------------------
  // high-speed decoders
  // --------------------------------------------------------------------
  logic [3:0] fb_hs_ratio;   // feedback high-speed ratio
  logic [3:0] pre_ratio;     // shared output prescaler ratio
  logic pre_skew_block;      // prescaler code zero

  hs_decode u_fb_hs (
    .code_in(active_w[4][14:12]),
    .ratio_out(fb_hs_ratio),
    .skew_block_out()
  );

  hs_decode u_pre_hs (
    .code_in(shared_output_prescaler_code_in),
    .ratio_out(pre_ratio),
    .skew_block_out(pre_skew_block)
  );

  // --------------------------------------------------------------------
  // registered divider outputs
  // --------------------------------------------------------------------
  // zero or odd is the only legal output setting; flagged for out3..out5 only (out2 has no flag), not altered
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      second_output_divider_out <= RST_LOW[15:0];
      third_output_divider_out <= RST_LOW;
      fourth_output_divider_out <= RST_LOW;
      fifth_output_divider_out <= RST_LOW;
      div_legal_out <= 3'h7;
    end else begin
      second_output_divider_out <= active_w[0][15:0];
      third_output_divider_out <= active_w[1];
      fourth_output_divider_out <= active_w[2];
      fifth_output_divider_out <= active_w[3];
      for (int c = 0; c < 3; c++) begin
        div_legal_out[c] <= (active_w[c+1] == 20'h0_0000) ||
                            active_w[c+1][0];
      end
    end
  end

  // feedback field holds ratio minus one; odd fields give even ratios
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      feedback_highspeed_ratio_out <= 4'ha;
      feedback_lowspeed_ratio_out <= 21'h00_0001;
      feedback_lowspeed_legal_out <= 1'b0;
      shared_output_prescaler_ratio_out <= `CDR_HS_RATIO_BASE;
      coarse_skew_block_out <= 1'b1;
    end else begin
      feedback_highspeed_ratio_out <= fb_hs_ratio;
      feedback_lowspeed_ratio_out <=
        {1'b0, active_w[4][11:0], fb_lowspeed_low_byte_in} +
        21'h00_0001;
      feedback_lowspeed_legal_out <= fb_lowspeed_low_byte_in[0];
      shared_output_prescaler_ratio_out <= pre_ratio;
      coarse_skew_block_out <= pre_skew_block;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  sequence s_partial_write;
    wr_hit && !is_commit;
  endsequence

  sequence s_commit_write;
    wr_hit && is_commit;
  endsequence

  a_partial_hold: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    s_partial_write |=> ##1 $stable(active_w))
    else $error("ratio changed on a partial write");

  a_commit_load: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    s_commit_write |=> ##1 (active_w == $past(staged_w)))
    else $error("committed ratio not loaded");

  a_reset_bytes: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> regs_r[1] == 8'h31 && regs_r[4] == 8'h31 &&
      regs_r[0] == 8'h00 && regs_r[8] == 8'h00)
    else $error("divider byte reset value wrong");

  a_reset_fbctrl: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> regs_r[11] == 8'hc0 ##1 fb_hs_ratio == 4'ha)
    else $error("feedback control reset value wrong");

  a_reserved_zero: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    reg_rd_in && reg_addr_in == `CDR_FB_CTRL_OFS |=>
      reg_rdata_out[`CDR_RSVD_BIT] == 1'b0 && reg_rvalid_out)
    else $error("reserved bit read back nonzero");

  a_out3_legal: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    div_legal_out[0] == (third_output_divider_out == 20'h0_0000 ||
                         third_output_divider_out[0]))
    else $error("third output legal flag wrong");

  a_out4_legal: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    div_legal_out[1] == (fourth_output_divider_out == 20'h0_0000 ||
                         fourth_output_divider_out[0]))
    else $error("fourth output legal flag wrong");

  a_out5_legal: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    div_legal_out[2] == (fifth_output_divider_out == 20'h0_0000 ||
                         fifth_output_divider_out[0]))
    else $error("fifth output legal flag wrong");

  a_fb_lowspeed: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ##1 feedback_lowspeed_legal_out == !feedback_lowspeed_ratio_out[0])
    else $error("feedback ratio parity and legal flag disagree");

  a_fb_highspeed: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    feedback_highspeed_ratio_out >= 4'h4 &&
      feedback_highspeed_ratio_out <= 4'hb)
    else $error("feedback high-speed ratio out of range");

  a_prescale_skew: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    shared_output_prescaler_code_in == 3'h0 |=> coarse_skew_block_out &&
      shared_output_prescaler_ratio_out == 4'h4)
    else $error("prescaler code zero not decoded");

endmodule
`default_nettype wire

// ### verification/clock_divider_config_regs_bench.sv
// self-checking bench for the divider configuration bank
`timescale 1ns/1ps
`default_nettype none
module clock_divider_config_regs_bench;
  // --------------------------------------------------------------------
  // port drive and observation
  // --------------------------------------------------------------------
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] fb_lowspeed_low_byte_in = 8'h00;
  logic [2:0] shared_output_prescaler_code_in = 3'h0;
  logic [7:0] reg_rdata_out;
  logic reg_rvalid_out;
  logic [15:0] second_output_divider_out;
  logic [19:0] third_output_divider_out;
  logic [19:0] fourth_output_divider_out;
  logic [19:0] fifth_output_divider_out;
  logic [2:0] div_legal_out;
  logic [3:0] feedback_highspeed_ratio_out;
  logic [20:0] feedback_lowspeed_ratio_out;
  logic feedback_lowspeed_legal_out;
  logic [3:0] shared_output_prescaler_ratio_out;
  logic coarse_skew_block_out;
  // --------------------------------------------------------------------
  // reference model and bookkeeping
  // --------------------------------------------------------------------
  clkdiv_pkg::byte_t m_reg [13];  // readback image of 0x1d..0x29
  clkdiv_pkg::byte_t exp_q [$];   // read answers still owed
  clkdiv_pkg::byte_t base [5] = '{8'h1d, 8'h1f, 8'h22, 8'h25, 8'h28};
  logic [15:0] m_out2;
  logic [19:0] m_out3, m_out4, m_out5;
  logic [2:0] m_hs;               // committed feedback code
  logic [11:0] m_ls_hi;           // committed feedback upper bits
  integer seed = 59;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  clkdiv_pkg::byte_t b;
  int n;

  clkdiv_cfg_regs u_clkdiv_cfg_regs (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .fb_lowspeed_low_byte_in(fb_lowspeed_low_byte_in),
    .shared_output_prescaler_code_in(shared_output_prescaler_code_in),
    .second_output_divider_out(second_output_divider_out),
    .third_output_divider_out(third_output_divider_out),
    .fourth_output_divider_out(fourth_output_divider_out),
    .fifth_output_divider_out(fifth_output_divider_out),
    .div_legal_out(div_legal_out),
    .feedback_highspeed_ratio_out(feedback_highspeed_ratio_out),
    .feedback_lowspeed_ratio_out(feedback_lowspeed_ratio_out),
    .feedback_lowspeed_legal_out(feedback_lowspeed_legal_out),
    .shared_output_prescaler_ratio_out(shared_output_prescaler_ratio_out),
    .coarse_skew_block_out(coarse_skew_block_out)
  );

  // 200 MHz system clock
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  // --------------------------------------------------------------------
  // compare and closing tasks
  // --------------------------------------------------------------------
  task automatic test_done();
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp_out(input logic [20:0] got, input logic [20:0] exp,
                         input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  task automatic cmp_rd(input clkdiv_pkg::byte_t got,
                        input clkdiv_pkg::byte_t exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: read got %h want %h", $time, got, exp);
    end
  endtask

  // zero or odd is the only legal output ratio
  function automatic logic lg(input logic [19:0] r);
    return (r == 20'h0_0000) || r[0];
  endfunction

  // --------------------------------------------------------------------
  // drivers: each strobe is raised for one edge, then a gap edge
  // --------------------------------------------------------------------
  task automatic do_reset(input int cycles);
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (cycles) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    m_reg = '{8'h00, 8'h31, 8'h00, 8'h00, 8'h31, 8'h00, 8'h00, 8'h31,
              8'h00, 8'h00, 8'h31, 8'hc0, 8'h00};
    m_out2 = 16'h0031;
    m_out3 = 20'h0_0031;
    m_out4 = 20'h0_0031;
    m_out5 = 20'h0_0031;
    m_hs = 3'h6;
    m_ls_hi = 12'h000;
  endtask

  task automatic wr(input clkdiv_pkg::byte_t a, input clkdiv_pkg::byte_t d);
    clkdiv_pkg::byte_t mk;
    int i;
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    // reserved bits drop on write
    mk = (a == 8'h1f || a == 8'h22 || a == 8'h25) ? 8'h0f :
         (a == 8'h28) ? 8'hef : 8'hff;
    i = int'(a) - 'h1d;
    if (i >= 0 && i < 13) begin
      m_reg[i] = d & mk;
    end
    // a ratio moves to its active copy only on its last byte
    case (a)
      8'h1e: m_out2 = {m_reg[0], m_reg[1]};
      8'h21: m_out3 = {m_reg[2][3:0], m_reg[3], m_reg[4]};
      8'h24: m_out4 = {m_reg[5][3:0], m_reg[6], m_reg[7]};
      8'h27: m_out5 = {m_reg[8][3:0], m_reg[9], m_reg[10]};
      8'h29: begin
        m_hs = m_reg[11][7:5];
        m_ls_hi = {m_reg[11][3:0], m_reg[12]};
      end
      default: ;
    endcase
  endtask

  task automatic rd(input clkdiv_pkg::byte_t a, input clkdiv_pkg::byte_t e);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
  endtask

  task automatic read_all();
    for (int i = 0; i < 13; i++) begin
      rd(8'(8'h1d + i), m_reg[i]);
    end
  endtask

  // outputs follow a commit two edges later; four gives margin
  task automatic settle();
    repeat (4) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic check_outs();
    logic [20:0] ls;
    ls = {1'b0, m_ls_hi, fb_lowspeed_low_byte_in} + 21'h0_0001;
    cmp_out(21'(second_output_divider_out), 21'(m_out2), "out2");
    cmp_out(21'(third_output_divider_out), 21'(m_out3), "out3");
    cmp_out(21'(fourth_output_divider_out), 21'(m_out4), "out4");
    cmp_out(21'(fifth_output_divider_out), 21'(m_out5), "out5");
    cmp_out(21'(div_legal_out), 21'({lg(m_out5), lg(m_out4), lg(m_out3)}),
            "legal");
    cmp_out(21'(feedback_highspeed_ratio_out), 21'(m_hs) + 21'h0_0004,
            "fb hs");
    cmp_out(feedback_lowspeed_ratio_out, ls, "fb ls");
    cmp_out(21'(feedback_lowspeed_legal_out),
            21'(fb_lowspeed_low_byte_in[0]), "fb legal");
    cmp_out(21'(shared_output_prescaler_ratio_out),
            21'(shared_output_prescaler_code_in) + 21'h0_0004,
            "prescaler");
    cmp_out(21'(coarse_skew_block_out),
            21'(shared_output_prescaler_code_in == 3'h0), "skew");
  endtask

  // --------------------------------------------------------------------
  // answer watcher and hang guard
  // --------------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (reg_rvalid_out === 1'b1) begin
      if (exp_q.size() > 0) begin
        cmp_rd(reg_rdata_out, exp_q.pop_front());
      end else begin
        bad_count++;
        $display("wrong value at %0t: unrequested read answer", $time);
      end
    end
  end

  // whole run is about 1600 cycles; the 8000-cycle ceiling leaves room
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      $display("wrong value at %0t: run did not finish", $time);
      test_done();
    end
  end

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    do_reset(12);
    settle();
    check_outs();
    read_all();
    // unmapped places: writes ignored, reads answer zero
    wr(8'h2a, 8'h5a);
    wr(8'h1c, 8'h5a);
    rd(8'h2a, 8'h00);
    rd(8'h1c, 8'h00);
    read_all();
    // first pass all zeros, second all ones but feedback code 001, then random bytes
    for (int it = 0; it < 16; it++) begin
      @(posedge clk_sys_in);
      fb_lowspeed_low_byte_in <= 8'($random(seed));
      shared_output_prescaler_code_in <= it[2:0];
      for (int g = 0; g < 5; g++) begin
        n = (g == 0 || g == 4) ? 2 : 3;
        for (int k = 0; k < n; k++) begin
          b = (it == 0) ? 8'h00 : (it == 1) ? 8'hff : 8'($random(seed));
          if (g == 4 && k == 0) begin
            b[7:5] = it[2:0];
          end
          if (k == n - 1) begin
            settle();
            check_outs();
          end
          wr(8'(base[g] + k), b);
        end
        settle();
        check_outs();
      end
      read_all();
    end
    // reset in mid-run brings back every reset value
    repeat (3) @(posedge clk_sys_in);
    do_reset(2);
    settle();
    check_outs();
    read_all();
    repeat (3) @(posedge clk_sys_in);
    cmp_out(21'(exp_q.size()), 21'h0_0000, "answers owed");
    test_done();
  end
endmodule
`default_nettype wire
